//--- video_pixel_output_port.sv
`timescale 1ns/100ps
`include "pixel_out_regs.svh"
// Notes on behaviour
// (R1) Three output modes: line-locked sync, device-paced FIFO, receiver-paced FIFO.
// (R2) Sync mode launches on full-rate clock for 8 bits, half-rate for 16.
// (R3) Sync mode may carry timing codes embedded in the pixel stream.
// (R4) FIFO modes output only active pixels and codes, timed by the FIFO read clock.
// (R5) Pixels are buffered in a FIFO of 512 entries, 20 bits each.
// (R6) FIFO modes drive line-active and field-active flags during viewable periods only.
// (R7) FIFO modes always present 16-bit data, whatever the width setting.
// (R8) After reset the output is sync mode, 8 bits, 4:2:2 embedded codes.
// (R9) 8-bit sync uses upper byte, chroma before luma, new byte per tick.
// (R10) 16-bit sync drives luma on upper byte, chroma on lower, half rate.
// (R11) FIFO modes write only active pixels and codes; others are discarded.
// (R12) Receiver read clock must outrun the active pixel write rate.
// (R13) Device-paced mode ties data-valid to FIFO read enable internally.
// (R14) Device-paced data-valid rises with almost-full and holds until empty.
// (R15) Device-paced data-valid leads first data by two full-rate clock cycles.
// (R16) Device-paced qualified clock runs only while valid data leaves.
// (R17) Receiver-paced: receiver watches flags and drives the read enable.
// (R18) Receiver-paced qualified clock runs continuously.
// (R19) One bit sets flag polarity; another sets data-valid polarity.
// (R20) Output clock tracks line length, fixed 27 MHz, or programmed value.
// (R21) Bit 6 of register 28h selects the programmed clock value.
// (R22) Manual clock equals value over 2^20 times 28 times 3/16 times 27 MHz.
// (R23) Programmed clock value is 18 bits wide.
// (R24) 8-bit chroma alternates blue and red difference in 4:2:2 order.
module video_pixel_output_port (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input pixel_out_pkg::pixel_in_type pix_in_i,
  input wire logic pix_in_valid_i,
  output logic pix_in_ready_o,
  input wire logic line_lock_tick_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic fifo_read_clock_i,
  input wire logic fifo_read_enable_i,
  output logic [15:0] pix_o,
  output logic line_active_flag_o,
  output logic field_active_flag_o,
  output logic data_valid_out_o,
  output logic fifo_almost_full_o,
  output logic fifo_almost_empty_o,
  output logic qualified_out_clock_o,
  output logic line_clock_full_rate_o,
  output logic line_clock_half_rate_o
);

  // Register file
  logic [7:0] out_ctrl, next_out_ctrl;
  logic manual_clock_enable, next_manual_clock_enable;
  logic [17:0] manual_clock_value, next_manual_clock_value; // see (R23)
  logic [7:0] rdata, next_rdata;

  always_comb
  begin
    next_out_ctrl = out_ctrl;
    next_manual_clock_enable = manual_clock_enable;
    next_manual_clock_value = manual_clock_value;
    next_rdata = 8'h00;
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        `OUT_CTRL_ADDR: next_out_ctrl = reg_wdata_i;
        `MCLK_CTRL_ADDR:
        begin
          next_manual_clock_enable = reg_wdata_i[`MCLK_EN_BIT]; // see (R21)
          next_manual_clock_value[17:16] = reg_wdata_i[1:0];
        end
        `MCLK_MID_ADDR: next_manual_clock_value[15:8] = reg_wdata_i;
        `MCLK_LOW_ADDR: next_manual_clock_value[7:0] = reg_wdata_i;
        default: next_rdata = 8'h00;
      endcase
    end
    unique case (reg_addr_i)
      `OUT_CTRL_ADDR: next_rdata = out_ctrl;
      `MCLK_CTRL_ADDR: next_rdata = {1'b0, manual_clock_enable, 4'h0, manual_clock_value[17:16]};
      `MCLK_MID_ADDR: next_rdata = manual_clock_value[15:8];
      `MCLK_LOW_ADDR: next_rdata = manual_clock_value[7:0];
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      out_ctrl <= `OUT_CTRL_RESET; // see (R8)
      manual_clock_enable <= `MCLK_EN_RESET;
      manual_clock_value <= `MCLK_VAL_RESET;
      rdata <= 8'h00;
    end
    else
    begin
      out_ctrl <= next_out_ctrl;
      manual_clock_enable <= next_manual_clock_enable;
      manual_clock_value <= next_manual_clock_value;
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;

  // Control decode; unused mode code falls back to sync
  pixel_out_pkg::out_mode_type mode;
  logic fifo_mode, wide, embed, flag_pol, valid_pol;
  always_comb
  begin
    unique case (out_ctrl[`OUT_MODE_MSB:`OUT_MODE_LSB]) // see (R1)
      2'h1: mode = pixel_out_pkg::MODE_DEVICE_PACED;
      2'h2: mode = pixel_out_pkg::MODE_RECEIVER_PACED;
      default: mode = pixel_out_pkg::MODE_SYNC;
    endcase
  end
  assign fifo_mode = (mode != pixel_out_pkg::MODE_SYNC);
  assign wide = out_ctrl[`OUT_WIDE_BIT] || fifo_mode; // see (R7)
  assign embed = out_ctrl[`OUT_EMBED_BIT];
  assign flag_pol = out_ctrl[`OUT_FLAG_POL_BIT];
  assign valid_pol = out_ctrl[`OUT_VALID_POL_BIT];

  // Line clock synthesis by phase accumulator
  logic [19:0] acc, next_acc, step;
  logic [29:0] manual_product;
  logic carry, tick, half_phase, next_half_phase, half_tick;
  assign manual_product = manual_clock_value * `MANUAL_SCALE; // see (R22)
  always_comb
  begin
    if (manual_clock_enable)
    begin
      step = {2'b00, manual_product[29:`MANUAL_SCALE_SHIFT]}; // see (R21)
    end
    else
    begin
      step = `FIXED_27_STEP;
    end
    {carry, next_acc} = {1'b0, acc} + {1'b0, step};
    if (manual_clock_enable || out_ctrl[`OUT_FIXED_CLK_BIT]) // see (R20)
    begin
      tick = carry;
    end
    else
    begin
      tick = line_lock_tick_i;
    end
    next_half_phase = tick ? ~half_phase : half_phase;
  end
  assign half_tick = tick && half_phase; // see (R2)

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      acc <= 20'h00000;
      half_phase <= 1'b0;
      line_clock_full_rate_o <= 1'b0;
      line_clock_half_rate_o <= 1'b0;
    end
    else
    begin
      acc <= next_acc;
      half_phase <= next_half_phase;
      line_clock_full_rate_o <= tick;
      line_clock_half_rate_o <= half_tick;
    end
  end

  // Input buffer ahead of the formatter
  pixel_out_pkg::pixel_in_type px;
  logic px_valid, px_ready;
  two_entry_buffer in_buf (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .in_data_i(pix_in_i),
    .in_valid_i(pix_in_valid_i),
    .in_ready_o(pix_in_ready_o),
    .out_data_o(px),
    .out_valid_o(px_valid),
    .out_ready_i(px_ready)
  );

  // FIFO storage and pointers
  pixel_out_pkg::fifo_word_type mem [512];
  pixel_out_pkg::fifo_word_type wr_word, rd_word;
  logic [`FIFO_AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [9:0] count, next_count;
  logic fifo_full, fifo_empty, fifo_wr, fifo_rd, keep;
  logic cr_sel, next_cr_sel, byte_sel, next_byte_sel;
  logic [7:0] chroma;
  assign fifo_full = (count == `FIFO_DEPTH); // see (R5)
  assign fifo_empty = (count == 10'd0);
  assign chroma = cr_sel ? px.cr : px.cb; // see (R24)
  assign keep = (px.line_act && px.field_act) || px.is_code; // see (R11)
  assign fifo_wr = fifo_mode && px_valid && keep && !fifo_full;
  assign wr_word = '{y: px.y, c: chroma, is_code: px.is_code, line_act: px.line_act,
                     field_act: px.field_act, spare: 1'b0};
  assign rd_word = mem[rd_ptr];

  // Read clock pin and read enable pin synchronisers
  logic rclk_s1, rclk_s2, rclk_s3, ren_s1, ren_s2, rd_edge;
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rclk_s1 <= 1'b0;
      rclk_s2 <= 1'b0;
      rclk_s3 <= 1'b0;
      ren_s1 <= 1'b0;
      ren_s2 <= 1'b0;
    end
    else
    begin
      rclk_s1 <= fifo_read_clock_i;
      rclk_s2 <= rclk_s1;
      rclk_s3 <= rclk_s2;
      ren_s1 <= fifo_read_enable_i;
      ren_s2 <= ren_s1;
    end
  end
  assign rd_edge = rclk_s2 && !rclk_s3; // see (R4)

  // Device pacing state
  pixel_out_pkg::pace_state_type pace, next_pace;
  logic [1:0] lead_cnt, next_lead_cnt;
  logic dv_int;
  always_comb
  begin
    next_pace = pace;
    next_lead_cnt = lead_cnt;
    unique case (pace)
      pixel_out_pkg::DP_IDLE:
      begin
        next_lead_cnt = 2'd0;
        if (mode == pixel_out_pkg::MODE_DEVICE_PACED && count >= `FIFO_AFULL_LEVEL)
        begin
          next_pace = pixel_out_pkg::DP_LEAD; // see (R14)
        end
      end
      pixel_out_pkg::DP_LEAD:
      begin
        if (tick)
        begin
          next_lead_cnt = lead_cnt + 2'd1;
        end
        if (tick && lead_cnt == `LEAD_TICKS - 2'd1)
        begin
          next_pace = pixel_out_pkg::DP_READ; // see (R15)
        end
      end
      pixel_out_pkg::DP_READ:
      begin
        if (fifo_empty || mode != pixel_out_pkg::MODE_DEVICE_PACED)
        begin
          next_pace = pixel_out_pkg::DP_IDLE; // see (R14)
        end
      end
    endcase
  end
  assign dv_int = (pace != pixel_out_pkg::DP_IDLE);

  // Read decision per mode
  always_comb
  begin
    unique case (mode)
      pixel_out_pkg::MODE_DEVICE_PACED: fifo_rd = rd_edge && pace == pixel_out_pkg::DP_READ && !fifo_empty; // see (R13)
      pixel_out_pkg::MODE_RECEIVER_PACED: fifo_rd = rd_edge && ren_s2 && !fifo_empty; // see (R17)
      default: fifo_rd = 1'b0;
    endcase
  end

  // Sync formatter pacing and buffer drain
  always_comb
  begin
    next_byte_sel = byte_sel;
    next_cr_sel = cr_sel;
    px_ready = 1'b0;
    if (fifo_mode)
    begin
      px_ready = !fifo_full;
    end
    else if (wide ? half_tick : tick)
    begin
      px_ready = wide || byte_sel;
      next_byte_sel = wide ? 1'b0 : byte_sel ^ px_valid; // Hold phase while nothing waits, see (R9)
    end
    if (px_valid && px_ready)
    begin
      next_cr_sel = px.is_code ? 1'b0 : ~cr_sel;
    end
    next_wr_ptr = fifo_wr ? wr_ptr + 9'd1 : wr_ptr;
    next_rd_ptr = fifo_rd ? rd_ptr + 9'd1 : rd_ptr;
    next_count = count + {9'd0, fifo_wr} - {9'd0, fifo_rd};
  end

  // Output data for each mode
  logic [15:0] next_pix;
  logic next_line_flag, next_field_flag;
  always_comb
  begin
    next_pix = pix_o;
    next_line_flag = 1'b0;
    next_field_flag = 1'b0;
    if (fifo_mode)
    begin
      next_line_flag = line_active_flag_o;
      next_field_flag = field_active_flag_o;
      if (fifo_rd)
      begin
        next_pix = {rd_word.y, rd_word.c}; // see (R7)
        next_line_flag = rd_word.line_act; // see (R6)
        next_field_flag = rd_word.field_act;
      end
    end
    else if (px_valid && (px.is_code ? embed : 1'b1)) // see (R3)
    begin
      if (wide && half_tick)
      begin
        next_pix = {px.y, chroma}; // see (R10)
      end
      else if (!wide && tick)
      begin
        next_pix = {byte_sel ? px.y : chroma, 8'h00}; // see (R9)
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (fifo_wr)
    begin
      mem[wr_ptr] <= wr_word;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr <= 9'h000;
      rd_ptr <= 9'h000;
      count <= 10'h000;
      cr_sel <= 1'b0;
      byte_sel <= 1'b0;
      pace <= pixel_out_pkg::DP_IDLE;
      lead_cnt <= 2'd0;
      pix_o <= 16'h0000;
      line_active_flag_o <= 1'b0;
      field_active_flag_o <= 1'b0;
      data_valid_out_o <= 1'b0;
      fifo_almost_full_o <= 1'b0;
      fifo_almost_empty_o <= 1'b0;
      qualified_out_clock_o <= 1'b0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      cr_sel <= next_cr_sel;
      byte_sel <= next_byte_sel;
      pace <= next_pace;
      lead_cnt <= next_lead_cnt;
      pix_o <= next_pix;
      line_active_flag_o <= next_line_flag;
      field_active_flag_o <= next_field_flag;
      data_valid_out_o <= (next_pace != pixel_out_pkg::DP_IDLE) ^ valid_pol; // Same edge as almost full, see (R14) (R19)
      fifo_almost_full_o <= (count >= `FIFO_AFULL_LEVEL) ^ flag_pol; // see (R19)
      fifo_almost_empty_o <= (count <= `FIFO_AEMPTY_LEVEL) ^ flag_pol;
      if (mode == pixel_out_pkg::MODE_RECEIVER_PACED)
      begin
        qualified_out_clock_o <= rclk_s2; // see (R18)
      end
      else
      begin
        qualified_out_clock_o <= rclk_s2 && pace == pixel_out_pkg::DP_READ && !fifo_empty; // see (R16)
      end
    end
  end

  a_fifo_only_active: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see (R11)
    fifo_wr |-> (px.line_act && px.field_act) || px.is_code) else $error("inactive sample written");
  a_fifo_count_up: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see (R5)
    fifo_wr && !fifo_rd |=> count == $past(count) + 10'd1 && count <= 10'd512) else $error("count wrong");
  a_dv_with_full: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see (R14)
    $rose(dv_int) |-> $past(count) >= 10'd384) else $error("valid rose without almost full");
  a_dv_holds: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see (R14)
    pace == pixel_out_pkg::DP_READ && !fifo_empty && mode == pixel_out_pkg::MODE_DEVICE_PACED |=> dv_int)
    else $error("valid dropped before empty");
  a_lead_no_read: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see (R15)
    pace != pixel_out_pkg::DP_READ && mode != pixel_out_pkg::MODE_RECEIVER_PACED |-> !fifo_rd)
    else $error("read before lead time");
  a_qualified_out_clock_gated: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see (R16)
    mode == pixel_out_pkg::MODE_DEVICE_PACED && pace != pixel_out_pkg::DP_READ |=> !qualified_out_clock_o)
    else $error("qualified clock ran while idle");
  a_qualified_out_clock_free: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see (R18)
    mode == pixel_out_pkg::MODE_RECEIVER_PACED |=> qualified_out_clock_o == $past(rclk_s2))
    else $error("qualified clock gated");
  a_flag_polarity: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see (R19)
    ##1 fifo_almost_full_o == (($past(count) >= 10'd384) ^ $past(flag_pol))) else $error("flag polarity wrong");
  a_manual_step: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see (R21)
    manual_clock_enable |-> step == {2'b00, manual_product[29:12]}) else $error("manual step not used");
  a_chroma_first: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // see (R9)
    !fifo_mode && !wide && tick && !byte_sel && px_valid && !px.is_code |=> pix_o[15:8] == $past(chroma))
    else $error("chroma byte not first");

endmodule

//--- pixel_out_regs.svh
`ifndef PIXEL_OUT_REGS_SVH
`define PIXEL_OUT_REGS_SVH

// Register subaddresses
`define OUT_CTRL_ADDR 8'h03
`define MCLK_CTRL_ADDR 8'h28
`define MCLK_MID_ADDR 8'h29
`define MCLK_LOW_ADDR 8'h2A

// Output control fields
`define OUT_CTRL_RESET 8'h08
`define OUT_MODE_LSB 0
`define OUT_MODE_MSB 1
`define OUT_WIDE_BIT 2
`define OUT_EMBED_BIT 3
`define OUT_FLAG_POL_BIT 4
`define OUT_VALID_POL_BIT 5
`define OUT_FIXED_CLK_BIT 6

// Manual clock fields
`define MCLK_EN_BIT 6
`define MCLK_VAL_RESET 18'h00000
`define MCLK_EN_RESET 1'b0

// FIFO geometry and levels
`define FIFO_DEPTH 10'd512
`define FIFO_AW 9
`define FIFO_AFULL_LEVEL 10'd384
`define FIFO_AEMPTY_LEVEL 10'd64

// Clock synthesis against the 200 MHz reference
`define REF_CLK_MHZ 200
`define FIXED_27_STEP 20'd141558
`define MANUAL_SCALE 12'd2903
`define MANUAL_SCALE_SHIFT 12
`define LEAD_TICKS 2'd2

`endif

//--- pixel_out_pkg.sv
package pixel_out_pkg;

  typedef enum logic [1:0] {
    MODE_SYNC,
    MODE_DEVICE_PACED,
    MODE_RECEIVER_PACED
  } out_mode_type;

  typedef enum logic [1:0] {
    DP_IDLE,
    DP_LEAD,
    DP_READ
  } pace_state_type;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] cb;
    logic [7:0] cr;
    logic is_code;
    logic line_act;
    logic field_act;
  } pixel_in_type;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] c;
    logic is_code;
    logic line_act;
    logic field_act;
    logic spare;
  } fifo_word_type;

endpackage

//--- two_entry_buffer.sv
`timescale 1ns/100ps
module two_entry_buffer (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input pixel_out_pkg::pixel_in_type in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output pixel_out_pkg::pixel_in_type out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  pixel_out_pkg::pixel_in_type slot [2];
  pixel_out_pkg::pixel_in_type next_slot [2];
  logic [1:0] count;
  logic [1:0] next_count;
  logic head;
  logic next_head;
  logic push;
  logic pop;

  // Handshakes straight from occupancy
  assign in_ready_o = (count != 2'd2);
  assign out_valid_o = (count != 2'd0);
  assign out_data_o = slot[head];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Next occupancy and storage
  always_comb
  begin
    next_slot = slot;
    next_head = head;
    next_count = count;
    if (push)
    begin
      next_slot[head ^ count[0]] = in_data_i;
    end
    if (pop)
    begin
      next_head = ~head;
    end
    if (push && !pop)
    begin
      next_count = count + 2'd1;
    end
    else if (pop && !push)
    begin
      next_count = count - 2'd1;
    end
  end

  // Register state
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      slot[0] <= '0;
      slot[1] <= '0;
      head <= 1'b0;
      count <= 2'd0;
    end
    else
    begin
      slot <= next_slot;
      head <= next_head;
      count <= next_count;
    end
  end

  // Never more than two words held
  a_buf_bound: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) count <= 2'd2) // see (R5)
    else $error("buffer count out of range");

endmodule

//--- fifo_reader_model.sv
`timescale 1ns/100ps
module fifo_reader_model #(parameter int HALF_NS = 10) (
  input wire logic run_i,
  input wire logic paced_i,
  input wire logic flag_pol_i,
  input wire logic almost_full_i,
  input wire logic almost_empty_i,
  output logic read_clock_o,
  output logic read_enable_o
);
  // Read clock well above the offered pixel rate, still while not running
  initial read_clock_o = 1'b0;
  always #(HALF_NS) read_clock_o = run_i ? ~read_clock_o : 1'b0;
  // Receiver pacing: start reading on almost full, stop on almost empty
  initial read_enable_o = 1'b0;
  always @(posedge read_clock_o)
  begin
    if (!paced_i)
      read_enable_o <= 1'b0;
    else if ((almost_full_i ^ flag_pol_i) === 1'b1)
      read_enable_o <= 1'b1;
    else if ((almost_empty_i ^ flag_pol_i) === 1'b1)
      read_enable_o <= 1'b0;
  end
endmodule

//--- video_pixel_output_port_tb.sv
`timescale 1ns/100ps
`include "pixel_out_regs.svh"
module video_pixel_output_port_tb;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  pixel_out_pkg::pixel_in_type pix_in_i = '0;
  logic pix_in_valid_i = 1'b0;
  logic tick = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic run = 1'b0;
  logic paced = 1'b0;
  logic ready, rdclk, rden, lact, fact, dv, af, ae, qualified_out_clock, line_clock_full_rate, line_clock_half_rate;
  logic [7:0] rdata;
  logic [15:0] pix;
  logic [15:0] last;
  logic [17:0] cap_q[$];
  logic [15:0] exp_q[$];
  pixel_out_pkg::pixel_in_type px_q[$];
  logic cap_on = 1'b0;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  video_pixel_output_port dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .pix_in_i(pix_in_i),
    .pix_in_valid_i(pix_in_valid_i), .pix_in_ready_o(ready), .line_lock_tick_i(tick), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .fifo_read_clock_i(rdclk),
    .fifo_read_enable_i(rden), .pix_o(pix), .line_active_flag_o(lact), .field_active_flag_o(fact),
    .data_valid_out_o(dv), .fifo_almost_full_o(af), .fifo_almost_empty_o(ae), .qualified_out_clock_o(qualified_out_clock),
    .line_clock_full_rate_o(line_clock_full_rate), .line_clock_half_rate_o(line_clock_half_rate));
  fifo_reader_model reader (.run_i(run), .paced_i(paced), .flag_pol_i(1'b0), .almost_full_i(af),
    .almost_empty_i(ae), .read_clock_o(rdclk), .read_enable_o(rden));

  // Clock and cycle ceiling
  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      stop_test();
    end
  end
  // Record each new value on the pixel bus, sampled when settled
  always @(negedge ref_clk_i)
  begin
    if (cap_on && pix !== last)
      cap_q.push_back({lact, fact, pix});
    last = pix;
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wr <= 1'b1;
    wdata <= d;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task automatic read_check(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr <= a;
    repeat (2) @(posedge ref_clk_i);
    #1 check("register", rdata, e);
  endtask
  task automatic send_all(input int gap);
    foreach (px_q[i])
    begin
      pix_in_i <= px_q[i];
      pix_in_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      while (ready !== 1'b1)
        @(posedge ref_clk_i);
      pix_in_valid_i <= 1'b0;
      repeat (gap) @(posedge ref_clk_i);
    end
  endtask
  task automatic ticks(input int n);
    repeat (3) @(posedge ref_clk_i);
    repeat (n)
    begin
      tick <= 1'b1;
      @(posedge ref_clk_i);
      tick <= 1'b0;
      repeat (7) @(posedge ref_clk_i);
    end
  endtask
  task automatic compare_cap(input int n);
    check("word count", cap_q.size() >= n, 1'b1);
    foreach (exp_q[i])
      if (i < n && i < cap_q.size())
        check("word", cap_q[i][15:0], exp_q[i]);
  endtask
  task automatic clear_all();
    px_q.delete();
    exp_q.delete();
    cap_q.delete();
  endtask
  task automatic test_regs();
    read_check(`OUT_CTRL_ADDR, 8'h08);
    read_check(`MCLK_CTRL_ADDR, 8'h00);
    check("idle bus", {pix, lact, fact, dv}, 19'h00000);
    reg_wr(`MCLK_MID_ADDR, 8'hAB);
    reg_wr(8'h7F, 8'h55);
    read_check(`MCLK_MID_ADDR, 8'hAB);
    read_check(8'h7F, 8'h00);
    $display("test_regs done");
  endtask
  task automatic test_sync(input logic wide);
    clear_all();
    for (int k = 0; k < 6; k++)
    begin
      px_q.push_back('{8'h10 + k[7:0], 8'h80 + k[7:0], (wide ? 8'h80 : 8'hC0) + k[7:0],
                       k == (wide ? 3 : 5), 1'b1, 1'b1});
      if (wide)
      begin
        if (k != 3)
          exp_q.push_back({8'h10 + k[7:0], 8'h80 + k[7:0]});
      end
      else
      begin
        exp_q.push_back({(k % 2 == 0 ? 8'h80 : 8'hC0) + k[7:0], 8'h00});
        exp_q.push_back({8'h10 + k[7:0], 8'h00});
      end
    end
    if (wide)
      reg_wr(`OUT_CTRL_ADDR, 8'h04); // 16-bit, codes not embedded
    cap_on = 1'b1;
    @(posedge ref_clk_i);
    fork
      send_all(1);
      ticks(16);
    join
    cap_on = 1'b0;
    compare_cap(wide ? 5 : 12);
    $display("test_sync done");
  endtask
  task automatic fifo_run(input logic [7:0] ctrl);
    int lead;
    int tog;
    logic q;
    lead = 0;
    tog = 0;
    clear_all();
    for (int i = 0; i < 500; i++)
    begin
      px_q.push_back('{i[7:0], ~i[7:0], ~i[7:0], 1'b0, i % 5 != 4, 1'b1});
      if (i % 5 != 4)
        exp_q.push_back({i[7:0], ~i[7:0]});
    end
    reg_wr(`OUT_CTRL_ADDR, ctrl);
    paced = (ctrl[1:0] == 2'd2);
    run = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    cap_on = 1'b1;
    fork
      send_all(6);
      if (ctrl[1:0] == 2'd1)
      begin
        q = 1'b1;
        while (dv !== 1'b1)
        begin
          q = af;
          @(negedge ref_clk_i);
        end
        check("almost full rises with valid", {q, af}, 2'b01);
        while (cap_q.size() == 0)
        begin
          @(negedge ref_clk_i);
          lead += line_clock_full_rate;
        end
      end
    join
    repeat (2000) @(posedge ref_clk_i);
    cap_on = 1'b0;
    q = qualified_out_clock;
    repeat (100)
    begin
      @(negedge ref_clk_i);
      tog += (qualified_out_clock !== q);
      q = qualified_out_clock;
    end
    compare_cap(ctrl[1:0] == 2'd1 ? 400 : 300);
    for (int i = 0; i < 300 && i < cap_q.size(); i++)
      check("line and field flags", cap_q[i][17:16], 2'b11);
    if (ctrl[1:0] == 2'd1)
    begin
      check("word total", cap_q.size(), 400);
      check("lead pulses", lead >= 2 && lead <= 3, 1'b1);
      check("gated clock", tog, 0);
      check("drained", {dv, af, ae}, 3'b001);
      reg_wr(`OUT_CTRL_ADDR, ctrl | 8'h30);
      repeat (3) @(posedge ref_clk_i);
      check("inverted flags", {dv, af, ae}, 3'b110);
    end
    else
      check("free clock", tog > 10, 1'b1);
    run = 1'b0;
    $display("fifo_run %0h done", ctrl);
  endtask
  task automatic rate_check(input real mhz);
    int cnt;
    int cnt2;
    int e;
    cnt = 0;
    cnt2 = 0;
    e = $rtoi(mhz * 20.0);
    repeat (4000)
    begin
      @(negedge ref_clk_i);
      cnt += line_clock_full_rate;
      cnt2 += line_clock_half_rate;
    end
    check("clock rate", cnt >= e - 3 && cnt <= e + 3, 1'b1);
    check("half rate clock", cnt2 >= e / 2 - 3 && cnt2 <= e / 2 + 3, 1'b1);
  endtask
  task automatic test_clocks();
    reg_wr(`OUT_CTRL_ADDR, 8'h40);
    rate_check(27.0);
    reg_wr(`MCLK_LOW_ADDR, 8'h66);
    reg_wr(`MCLK_MID_ADDR, 8'hD2);
    reg_wr(`MCLK_CTRL_ADDR, 8'h42);
    rate_check(184934.0 / 1048576.0 * 28.0 * 3.0 / 16.0 * 27.0);
    $display("test_clocks done");
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    test_regs();
    test_sync(1'b0);
    test_sync(1'b1);
    fifo_run(8'h41);
    fifo_run(8'h42);
    test_clocks();
    stop_test();
  end
endmodule
